/* hw/fsg_guard.v */
// Flash section guard: stall and access control between the core and
// its self-programmable flash, plus the boot protection fields.
// Assumes the core issues one-cycle store/load requests, obeys
// core_halt and fetch_ok, and the flash pulses fl_done once per job.
// Limitation: one erase or write at a time; the flash ends each job.
//
// Summary of operation
// - Halt decision follows target page region only
// - Concurrent target: core runs, stalling region readable
// - Stalling target: halt core, nothing readable
// - Concurrent region unreadable during any programming
// - Boot section always inside stalling region
// - Busy flag reads one while region blocked
// - Two independent two-bit protection fields
// - Bits only programmed; chip erase restores them
// - General write lock never blocks stores
// - General read/write lock never blocks loads
// - App field 11: no app restriction
// - App field 10 or 00: no app stores
// - App field 00 or 01: boot loads blocked
// - App modes 3,4: mask interrupts in app, vectors in boot
// - Boot field 11: no boot restriction
// - Boot field 10 or 00: no boot stores
// - Boot field 00 or 01: app loads blocked
// - Boot modes 3,4: mask interrupts in boot, vectors in app
// - Stores from application section are ignored
// - Flag cleared by re-enable or page load
`timescale 1ns/10ps
`default_nettype none
`include "fsg_guard_regs.vh"

module fsg_guard #(
  parameter AW = 12
) (
  input  wire          pclk,
  input  wire          presetn,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // Fuse and programming-mode inputs
  input  wire [1:0]    boot_size_select,
  input  wire          ext_lock_wr,
  input  wire [3:0]    ext_lock_data,
  input  wire          chip_erase,
  // Core: program-memory store
  input  wire          st_req,
  input  wire [1:0]    st_op,
  input  wire [AW-1:0] st_addr,
  input  wire [AW-1:0] st_pc,
  input  wire [3:0]    st_lock_data,
  output wire          st_taken,
  // Core: program-memory load
  input  wire          ld_req,
  input  wire [AW-1:0] ld_addr,
  input  wire [AW-1:0] ld_pc,
  output wire          ld_ok,
  // Core: fetch and interrupts
  input  wire [AW-1:0] fetch_pc,
  input  wire          vec_in_boot,
  output wire          fetch_ok,
  output wire          irq_disable,
  output reg           core_halt,
  // Flash array
  output reg           fl_start,
  output reg  [1:0]    fl_op,
  output reg  [AW-1:0] fl_addr,
  input  wire          fl_done
);

  // Job state, busy flag and guard bits; boot start is combinational
  // from the fuse level, so a fuse change takes effect at once
  reg  [1:0]    state_q;
  reg  [1:0]    state_d;
  reg           busy_q;
  reg  [3:0]    lock_q;
  reg  [AW-1:0] boot_start;

  // Section membership of every address the core can present
  wire          st_boot;
  wire          st_stall;
  wire          stpc_boot;
  wire          ld_boot;
  wire          ld_stall;
  wire          ldpc_boot;
  wire          fe_boot;
  wire          fe_stall;

  // Bus strobes, grants and the merged guard-bit programming word
  wire          apb_wr;
  wire          apb_rd;
  wire          reenable_req;
  wire          lock_sw_wr;
  wire          prog_busy;
  wire          st_ok_guard;
  wire          st_prog;
  wire          st_load;
  wire          st_lock;
  wire          ld_guard;
  wire [3:0]    lock_pgm;

  // Boot start from fuse size, clamped so it never dips below the
  // stalling region start whatever the size table holds. Boot code
  // runs the job, so it must stay readable during a concurrent job;
  // a larger table entry therefore can never expose it
  always @* begin
    case (boot_size_select)
      2'h0:    boot_start = `FSG_BOOT_SZ0;
      2'h1:    boot_start = `FSG_BOOT_SZ1;
      2'h2:    boot_start = `FSG_BOOT_SZ2;
      default: boot_start = `FSG_BOOT_SZ3;
    endcase
    if (boot_start < `FSG_STALL_START) begin
      boot_start = `FSG_STALL_START;
    end
  end

  // Region decode for store target, store origin, load, fetch.
  // Load and fetch grants answer in the same cycle, so every
  // decoder is a plain compare with no register
  fsg_sect_decode #(.AW(AW)) u_dec_st (
    .addr        (st_addr),
    .boot_start  (boot_start),
    .stall_start (`FSG_STALL_START),
    .in_boot     (st_boot),
    .in_stall    (st_stall)
  );

  fsg_sect_decode #(.AW(AW)) u_dec_stpc (
    .addr        (st_pc),
    .boot_start  (boot_start),
    .stall_start (`FSG_STALL_START),
    .in_boot     (stpc_boot),
    .in_stall    ()
  );

  fsg_sect_decode #(.AW(AW)) u_dec_ld (
    .addr        (ld_addr),
    .boot_start  (boot_start),
    .stall_start (`FSG_STALL_START),
    .in_boot     (ld_boot),
    .in_stall    (ld_stall)
  );

  fsg_sect_decode #(.AW(AW)) u_dec_ldpc (
    .addr        (ld_pc),
    .boot_start  (boot_start),
    .stall_start (`FSG_STALL_START),
    .in_boot     (ldpc_boot),
    .in_stall    ()
  );

  fsg_sect_decode #(.AW(AW)) u_dec_fe (
    .addr        (fetch_pc),
    .boot_start  (boot_start),
    .stall_start (`FSG_STALL_START),
    .in_boot     (fe_boot),
    .in_stall    (fe_stall)
  );

  // APB decode; zero wait states, so pready stays high.
  // Read data is captured in setup and stands through the access
  // phase; unmapped offsets answer with an error and change nothing
  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable &
                   (paddr != `FSG_OFF_CTRL) &
                   (paddr != `FSG_OFF_STAT) &
                   (paddr != `FSG_OFF_LOCK);

  assign reenable_req = apb_wr & (paddr == `FSG_OFF_CTRL) &
                        pwdata[`FSG_CTRL_REENABLE];
  assign lock_sw_wr   = apb_wr & (paddr == `FSG_OFF_LOCK);

  // Flash busy with an erase or write
  // Loads and lock sets never enter a job state
  assign prog_busy = (state_q != `FSG_ST_IDLE);

  // A zero low bit refuses stores into that section
  // Store permission from the guard fields. Only the low bit of each
  // field gates stores; no general chip lock level enters here
  assign st_ok_guard = st_boot ? lock_q[`FSG_BOOT_LO]
                               : lock_q[`FSG_APP_LO];

  // Stores count only from boot code while the flash is idle.
  // A refused store leaves no trace: no start, no flag change;
  // stores during a job are refused, so jobs never overlap
  assign st_prog = st_req & stpc_boot & ~prog_busy &
                   ((st_op == `FSG_OP_ERASE) |
                    (st_op == `FSG_OP_WRITE)) &
                   st_ok_guard;
  assign st_load = st_req & stpc_boot & ~prog_busy &
                   (st_op == `FSG_OP_LOAD);
  assign st_lock = st_req & stpc_boot & ~prog_busy &
                   (st_op == `FSG_OP_LOCK);
  assign st_taken = st_prog | st_load | st_lock;

  // Same-section loads are never guarded
  // Load guard: cross-section loads blocked by the high field bit;
  // the general read/write lock is not consulted
  assign ld_guard =
    (ld_boot & ~ldpc_boot & ~lock_q[`FSG_BOOT_HI]) |
    (~ld_boot & ldpc_boot & ~lock_q[`FSG_APP_HI]);

  // Gated by the busy flag, not the job state, so reads stay
  // blocked after completion until software re-enables the region.
  // Load grant: never into the concurrent region while it is blocked,
  // and nothing at all while halted
  assign ld_ok = ld_req & ~ld_guard & ~core_halt &
                 ~(busy_q & ~ld_stall);

  // Halt already covers a stalling job; busy only blocks fetches
  // below the stalling start.
  // Fetch permission: stalling region stays readable during a
  // concurrent-region job; decided by the region of fetch_pc, the busy flag and core_halt
  assign fetch_ok = ~core_halt &
                    ~(busy_q & ~fe_stall);

  // Interrupt masking by protection mode and vector placement.
  // Running section comes from fetch_pc, vector placement from the
  // core's own setting
  assign irq_disable =
    (~lock_q[`FSG_APP_HI] & vec_in_boot & ~fe_boot) |
    (~lock_q[`FSG_BOOT_HI] & ~vec_in_boot & fe_boot);

  // Protection bits can only be programmed (ones to zeros).
  // Bus, external and store writers may land in one cycle; ANDing
  // them means none of them is lost
  assign lock_pgm = (lock_sw_wr  ? pwdata[`FSG_LOCK_W-1:0] :
                                   `FSG_LOCK_ERASED) &
                    (ext_lock_wr ? ext_lock_data : `FSG_LOCK_ERASED) &
                    (st_lock     ? st_lock_data  : `FSG_LOCK_ERASED);

  // Guard field register; both fields change bit by bit, so neither
  // depends on the other. Chip erase or reset restores the erased value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= `FSG_LOCK_ERASED;
    end else if (chip_erase) begin
      lock_q <= `FSG_LOCK_ERASED;
    end else begin
      lock_q <= lock_q & lock_pgm;
    end
  end

  // Next state: region of the target page picks the job kind.
  // Only erase and write start a job; loads and lock sets end in
  // the cycle they are taken
  always @* begin
    state_d = state_q;
    case (state_q)
      `FSG_ST_IDLE: begin
        if (st_prog) begin
          state_d = st_stall ? `FSG_ST_STALL
                             : `FSG_ST_CONC;
        end
      end
      `FSG_ST_CONC: begin
        if (fl_done) begin
          state_d = `FSG_ST_IDLE;
        end
      end
      `FSG_ST_STALL: begin
        if (fl_done) begin
          state_d = `FSG_ST_IDLE;
        end
      end
      default: begin
        state_d = `FSG_ST_IDLE;
      end
    endcase
  end

  // State, halt and flash command registers.
  // fl_op and fl_addr hold the last erase, write or buffer load, so the flash may sample
  // them after the start pulse has gone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= `FSG_ST_IDLE;
      core_halt <= 1'b0;
      fl_start  <= 1'b0;
      fl_op     <= `FSG_OP_LOAD;
      fl_addr   <= {AW{1'b0}};
    end else begin
      state_q  <= state_d;
      fl_start <= st_prog | st_load;
      if (st_prog | st_load) begin
        fl_op   <= st_op;
        fl_addr <= st_addr;
      end
      // Halt for the whole stalling job, dropped once done is seen
      core_halt <= (state_d == `FSG_ST_STALL);
    end
  end

  // Busy flag: set when a concurrent-region job starts; cleared by a
  // re-enable once the flash is idle, or by a page-buffer load.
  // A start in the same cycle as a clear wins, so it is never lost.
  // A re-enable while a job runs is ignored; software must retry
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (st_prog & ~st_stall) begin
      busy_q <= 1'b1;
    end else if ((reenable_req & ~prog_busy) | st_load) begin
      busy_q <= 1'b0;
    end
  end

  // Read data captured in the setup phase, shown in the access phase
  // Status bits are sampled live at setup; unmapped offsets read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        `FSG_OFF_STAT: begin
          prdata[`FSG_STAT_BUSY]  <= busy_q;
          prdata[`FSG_STAT_HALT]  <= core_halt;
          prdata[`FSG_STAT_FLASH] <= prog_busy;
        end
        `FSG_OFF_LOCK: begin
          prdata[`FSG_LOCK_W-1:0] <= lock_q;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* hw/fsg_guard_regs.vh */
// Constants for the flash section guard: register map, field layout,
// store operation codes, section limits and controller states.
// Assumes word addresses of AW bits into program flash.
`ifndef FSG_GUARD_REGS_VH
`define FSG_GUARD_REGS_VH

// Register byte offsets on the APB bus
`define FSG_OFF_CTRL       12'h000
`define FSG_OFF_STAT       12'h004
`define FSG_OFF_LOCK       12'h008

// Control register fields (write side)
`define FSG_CTRL_REENABLE  4

// Status register fields (read side)
`define FSG_STAT_BUSY      0
`define FSG_STAT_HALT      1
`define FSG_STAT_FLASH     2

// Guard register fields: app field in [1:0], boot field in [3:2]
`define FSG_APP_LO         0
`define FSG_APP_HI         1
`define FSG_BOOT_LO        2
`define FSG_BOOT_HI        3
`define FSG_LOCK_W         4
`define FSG_LOCK_ERASED    4'hf

// Store operation codes from the core
`define FSG_OP_LOAD        2'h0
`define FSG_OP_ERASE       2'h1
`define FSG_OP_WRITE       2'h2
`define FSG_OP_LOCK        2'h3

// Section limits, word addresses, 4K-word flash
`define FSG_STALL_START    12'hc00
`define FSG_BOOT_SZ0       12'hf80
`define FSG_BOOT_SZ1       12'hf00
`define FSG_BOOT_SZ2       12'he00
`define FSG_BOOT_SZ3       12'hc00

// Controller states
`define FSG_ST_IDLE        2'h0
`define FSG_ST_CONC        2'h1
`define FSG_ST_STALL       2'h2

`endif

/* hw/fsg_sect_decode.v */
// Section decoder: sorts one flash word address into boot section
// and stalling region membership.
// Assumes both limits are stable and boot_start >= stall_start.
`timescale 1ns/10ps
`default_nettype none

module fsg_sect_decode #(
  parameter AW = 12
) (
  input  wire [AW-1:0] addr,
  input  wire [AW-1:0] boot_start,
  input  wire [AW-1:0] stall_start,
  output wire          in_boot,
  output wire          in_stall
);

  // Both sections sit at the top of flash, so a compare is enough
  assign in_boot  = (addr >= boot_start);
  assign in_stall = (addr >= stall_start);

endmodule

`default_nettype wire

/* testbench/fsg_flash_model.sv */
// Flash array stand-in: one done pulse per erase or write job.
// Assumes fl_start is a one-cycle pulse; slow picks the long delay.
`timescale 1ns/10ps
`default_nettype none
module fsg_flash_model #(
  parameter int FAST = 3,
  parameter int SLOW = 40
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic       fl_start,
  input  wire logic [1:0] fl_op,
  output var  logic       fl_done
);
  int cnt;
  // Buffer loads and lock sets finish at once, so they get no pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      fl_done <= 1'b0;
    end else begin
      fl_done <= cnt == 1;
      if (fl_start && (fl_op == 2'h1 || fl_op == 2'h2))
        cnt <= slow ? SLOW : FAST;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

/* testbench/fsg_guard_asserts.sv */
// Port checker for fsg_guard: halt, busy and store acceptance timing.
// Assumes pclk is the only clock and presetn resets asynchronously.
`timescale 1ns/10ps
`default_nettype none
module fsg_guard_asserts #(
  parameter AW = 12
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          st_req,
  input wire logic [1:0]    st_op,
  input wire logic [AW-1:0] st_addr,
  input wire logic [AW-1:0] st_pc,
  input wire logic          st_taken,
  input wire logic          ld_req,
  input wire logic [AW-1:0] ld_addr,
  input wire logic          ld_ok,
  input wire logic          core_halt,
  input wire logic          fl_start,
  input wire logic          fl_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted erase or write, then split by target region
  sequence s_job;
    st_taken && (st_op == 2'h1 || st_op == 2'h2);
  endsequence
  sequence s_conc;
    s_job ##0 st_addr < 12'hc00;
  endsequence
  a_halt_stall: assert property (
    s_job ##0 st_addr >= 12'hc00 |=> core_halt) else $error("no halt");
  a_run_conc: assert property (
    s_conc |=> !core_halt) else $error("halt on concurrent job");
  a_halt_hold: assert property (
    core_halt && !fl_done |=> core_halt) else $error("halt dropped");
  a_halt_release: assert property (
    core_halt && fl_done |=> !core_halt) else $error("halt kept");
  a_halt_noload: assert property (
    core_halt && ld_req |-> !ld_ok) else $error("load while halted");
  a_conc_block: assert property (
    s_conc ##[1:2] (ld_req && ld_addr < 12'hc00) |-> !ld_ok)
    else $error("concurrent region readable");
  a_app_store: assert property (
    st_req && st_pc < 12'hc00 |-> !st_taken) else $error("app store");
  a_start_cause: assert property (
    fl_start |-> $past(st_taken)) else $error("flash start unprompted");
endmodule
bind fsg_guard fsg_guard_asserts #(.AW(AW)) i_chk (
  .pclk(pclk), .presetn(presetn), .st_req(st_req), .st_op(st_op),
  .st_addr(st_addr), .st_pc(st_pc), .st_taken(st_taken),
  .ld_req(ld_req), .ld_addr(ld_addr), .ld_ok(ld_ok),
  .core_halt(core_halt), .fl_start(fl_start), .fl_done(fl_done)
);
`default_nettype wire

/* testbench/tb_fsg_guard.sv */
// Bench for fsg_guard: APB, store, load and fetch sequences.
// Assumes a 250 MHz pclk and the guard header's register layout.
`timescale 1ns/10ps
`default_nettype none
`include "fsg_guard_regs.vh"
module tb_fsg_guard;
  logic        pclk, presetn, psel, penable, pwrite, ext_lock_wr, slv;
  logic        chip_erase, st_req, ld_req, vec_in_boot, fl_slow;
  logic [11:0] paddr, st_addr, st_pc, ld_addr, ld_pc, fetch_pc, ta;
  logic [31:0] pwdata, rd;
  logic [1:0]  boot_size_select, st_op, f;
  logic [3:0]  ext_lock_data, st_lock_data, lk;
  wire  [31:0] prdata;
  wire  [11:0] fl_addr;
  wire  [1:0]  fl_op;
  wire         pready, pslverr, st_taken, ld_ok, fetch_ok, irq_disable;
  wire         core_halt, fl_start, fl_done;
  int          err_total = 0, n_tests = 0, cyc = 0;
  fsg_guard #(.AW(12)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .boot_size_select(boot_size_select), .ext_lock_wr(ext_lock_wr),
    .ext_lock_data(ext_lock_data), .chip_erase(chip_erase),
    .st_req(st_req), .st_op(st_op), .st_addr(st_addr), .st_pc(st_pc),
    .st_lock_data(st_lock_data), .st_taken(st_taken), .ld_req(ld_req),
    .ld_addr(ld_addr), .ld_pc(ld_pc), .ld_ok(ld_ok),
    .fetch_pc(fetch_pc), .vec_in_boot(vec_in_boot),
    .fetch_ok(fetch_ok), .irq_disable(irq_disable),
    .core_halt(core_halt), .fl_start(fl_start), .fl_op(fl_op),
    .fl_addr(fl_addr), .fl_done(fl_done)
  );
  fsg_flash_model i_flash (
    .pclk(pclk), .presetn(presetn), .slow(fl_slow),
    .fl_start(fl_start), .fl_op(fl_op), .fl_done(fl_done)
  );
  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; the answer is taken at the pready edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic store(logic [1:0] op, logic [11:0] a, pc, logic exp);
    @(posedge pclk);
    st_req <= 1'b1;
    st_op <= op;
    st_addr <= a;
    st_pc <= pc;
    #1 check("st_taken", st_taken, exp);
    @(posedge pclk);
    st_req <= 1'b0;
  endtask
  task automatic load(logic [11:0] a, pc, logic exp);
    @(posedge pclk);
    ld_req <= 1'b1;
    ld_addr <= a;
    ld_pc <= pc;
    #1 check("ld_ok", ld_ok, exp);
    @(posedge pclk);
    ld_req <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence; boot size 3 puts boot start at the region limit
  initial begin
    {psel, penable, pwrite, ext_lock_wr, chip_erase, st_req} = '0;
    {ld_req, vec_in_boot, fl_slow, paddr, pwdata, st_addr} = '0;
    {st_pc, ld_addr, ld_pc, fetch_pc, st_op, ext_lock_data} = '0;
    st_lock_data = '0;
    boot_size_select = 2'h3;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `FSG_OFF_LOCK, 0);
    check("lock reset", rd, 32'hf);
    apb(0, 12'h010, 0);
    check("pslverr", slv, 1);
    $display("reset test done");
    fl_slow <= 1'b1;
    store(`FSG_OP_WRITE, 12'hc40, 12'hc00, 1);
    #1 check("halt", core_halt, 1);
    check("fetch halt", fetch_ok, 0);
    check("fl_start", fl_start, 1);
    check("fl_addr", fl_addr, 12'hc40);
    check("fl_op", fl_op, `FSG_OP_WRITE);
    load(12'hc10, 12'hc00, 0);
    apb(0, `FSG_OFF_STAT, 0);
    check("stat halt", rd,
          32'h1 << `FSG_STAT_HALT | 32'h1 << `FSG_STAT_FLASH);
    @(posedge pclk iff fl_done === 1'b1);
    #1 check("halt end", core_halt, 0);
    $display("stall test done");
    fl_slow <= 1'b0;
    vec_in_boot <= 1'b1;
    store(`FSG_OP_ERASE, 12'h100, 12'hc00, 1);
    fetch_pc <= 12'hc10;
    #1 check("no halt", core_halt, 0);
    load(12'h100, 12'hc00, 0);
    #1 check("fetch run", fetch_ok, 1);
    load(12'hc10, 12'hc00, 1);
    fetch_pc <= 12'h100;
    #1 check("fetch block", fetch_ok, 0);
    apb(0, `FSG_OFF_STAT, 0);
    check("busy", rd[0], 1);
    apb(1, `FSG_OFF_CTRL, 32'h10);
    apb(0, `FSG_OFF_STAT, 0);
    check("busy off", rd[0], 0);
    load(12'h100, 12'hc00, 1);
    store(`FSG_OP_WRITE, 12'h100, 12'hc00, 1);
    repeat (8) @(posedge pclk);
    store(`FSG_OP_LOAD, 12'h100, 12'hc00, 1);
    apb(0, `FSG_OFF_STAT, 0);
    check("busy load", rd[0], 0);
    store(`FSG_OP_WRITE, 12'h100, 12'h100, 0);
    $display("concurrent test done");
    // Each field through all four codes, the other one left open
    for (int k = 0; k < 8; k++) begin
      f = k[1:0];
      chip_erase <= 1'b1;
      @(posedge pclk);
      chip_erase <= 1'b0;
      lk = k < 4 ? {2'h3, f} : {f, 2'h3};
      ta = k < 4 ? 12'h100 : 12'hc00;
      apb(1, `FSG_OFF_LOCK, {28'h0, lk});
      apb(0, `FSG_OFF_LOCK, 0);
      check("lock", rd, {28'h0, lk});
      vec_in_boot <= k < 4;
      fetch_pc <= ta;
      load(ta, k < 4 ? 12'hc00 : 12'h100, f[1]);
      check("irq_disable", irq_disable, !f[1]);
      store(`FSG_OP_WRITE, ta, 12'hc00, f[0]);
      repeat (10) @(posedge pclk);
      apb(1, `FSG_OFF_CTRL, 32'h10);
    end
    $display("guard test done");
    @(posedge pclk);
    ext_lock_wr <= 1'b1;
    ext_lock_data <= 4'h7;
    @(posedge pclk);
    ext_lock_wr <= 1'b0;
    apb(0, `FSG_OFF_LOCK, 0);
    check("ext lock", rd, 32'h7);
    st_lock_data <= 4'hb;
    store(`FSG_OP_LOCK, 12'h000, 12'hc00, 1);
    apb(0, `FSG_OFF_LOCK, 0);
    check("sw lock", rd, 32'h3);
    $display("lock set test done");
    // Smallest boot size: pc 0xc00 is application code now
    boot_size_select <= 2'h0;
    chip_erase <= 1'b1;
    @(posedge pclk);
    chip_erase <= 1'b0;
    store(`FSG_OP_WRITE, 12'h100, 12'hc00, 0);
    store(`FSG_OP_WRITE, 12'hf80, 12'hf80, 1);
    #1 check("boot halt", core_halt, 1);
    @(posedge pclk iff fl_done === 1'b1);
    $display("boot size test done");
    summarize();
  end
endmodule
`default_nettype wire
